// ==== hw/usb_control_endpoint_fifo.sv ====
// endpoint 0 control transfer engine and endpoint 1-5 configuration
`timescale 1ns/1ps
module usb_control_endpoint_fifo
	import usb_ep_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RESET_N,
	input  wire logic              TOK_VALID,
	input  wire logic [1:0]        TOK_PID,
	input  wire logic [3:0]        TOK_EP,
	input  wire logic              RX_VALID,
	input  wire logic [7:0]        RX_DATA,
	input  wire logic              RX_END,
	input  wire logic              HOST_ACK,
	input  wire logic              TX_REQ,
	output logic                   TX_START,
	output logic      [5:0]        TX_LEN,
	output logic      [7:0]        TX_DATA,
	output logic                   HS_VALID,
	output logic      [1:0]        HS_CODE,
	input  wire logic [2:0]        ENDPOINT_SELECT,
	input  wire logic              TX_PACKET_LOAD,
	input  wire logic              DATA_END_SET,
	input  wire logic              RX_PACKET_RELEASE,
	input  wire logic              FORCE_STALL_SET,
	input  wire logic              SENT_STALL_CLEAR,
	input  wire logic              PREMATURE_END_CLEAR,
	input  wire logic              IRQ_FLAGS_READ,
	input  wire logic              EP0_IRQ_MASK,
	input  wire logic              GLOBAL_USB_IRQ_ENABLE,
	input  wire logic              FIFO_WR,
	input  wire logic [7:0]        FIFO_WDATA,
	input  wire logic              FIFO_RD,
	output logic      [7:0]        FIFO_RDATA,
	input  wire logic              CFG_WR,
	input  wire logic [MAXP_W-1:0] CFG_IN_MAX,
	input  wire logic [MAXP_W-1:0] CFG_OUT_MAX,
	input  wire logic              CFG_IN_ISO,
	input  wire logic              CFG_OUT_ISO,
	input  wire logic              CFG_IN_DBL,
	input  wire logic              CFG_OUT_DBL,
	output logic      [MAXP_W-1:0] IN_MAX_PACKET_SIZE,
	output logic      [MAXP_W-1:0] OUT_MAX_PACKET_SIZE,
	output logic                   IN_ISO_SELECT,
	output logic                   OUT_ISO_SELECT,
	output logic      [ADDR_W-1:0] IN_BUF_ADDR,
	output logic      [ADDR_W-1:0] OUT_BUF_ADDR,
	output logic      [ADDR_W-1:0] IN_BUF2_ADDR,
	output logic      [ADDR_W-1:0] OUT_BUF2_ADDR,
	output logic                   CFG_FITS,
	output logic      [1:0]        EP0_STATE,
	output logic                   RX_PACKET_WAITING,
	output logic                   TX_PACKET_LOADED,
	output logic                   DATA_END,
	output logic                   FORCE_STALL,
	output logic                   SENT_STALL,
	output logic                   PREMATURE_END,
	output logic      [5:0]        EP0_RX_BYTE_COUNT,
	output logic                   EP0_IRQ_FLAG,
	output logic                   USB_IRQ
);
	typedef struct packed {
		ep0_state_t                   st;
		pkt_t                         pk;
		logic [5:0]                   wr_ptr;
		logic [5:0]                   rd_ptr;
		logic [5:0]                   rx_cnt;
		logic [5:0]                   tx_len;
		logic [5:0]                   cnt_out;
		logic                         rx_waiting;
		logic                         tx_loaded;
		logic                         data_end;
		logic                         send_stall;
		logic                         sent_stall;
		logic                         prem_end;
		logic                         irq_flag;
		logic                         has_data;
		logic                         dir_in;
		logic                         hs_valid;
		logic [1:0]                   hs_code;
		logic                         tx_start;
		logic [NUM_EP-1:0][MAXP_W-1:0] in_max;
		logic [NUM_EP-1:0][MAXP_W-1:0] out_max;
		logic [NUM_EP-1:0]            in_iso;
		logic [NUM_EP-1:0]            out_iso;
		logic [NUM_EP-1:0]            in_dbl;
		logic [NUM_EP-1:0]            out_dbl;
		logic [ADDR_W-1:0]            in_addr;
		logic [ADDR_W-1:0]            out_addr;
		logic [ADDR_W-1:0]            in2_addr;
		logic [ADDR_W-1:0]            out2_addr;
		logic                         fits;
	} ctl_t;

	ctl_t              r_reg;
	ctl_t              r_next;
	logic              mem_we;
	logic [4:0]        mem_waddr;
	logic [7:0]        mem_wdata;
	logic [7:0]        mem_rdata;
	logic              sel0;
	logic              sel_ok;
	logic [2:0]        sel_idx;
	logic              lay_dbl;
	logic [ADDR_W-1:0] lay_in;
	logic [ADDR_W-1:0] lay_out;
	logic [ADDR_W-1:0] lay_in2;
	logic [ADDR_W-1:0] lay_out2;
	logic              lay_fits;

	assign sel0    = (ENDPOINT_SELECT == EP0_SEL);
	assign sel_ok  = !sel0 && (ENDPOINT_SELECT <= 3'(NUM_EP));
	assign sel_idx = sel_ok ? (ENDPOINT_SELECT - 3'h1) : 3'h0;
	assign lay_dbl = r_reg.in_dbl[sel_idx] | r_reg.out_dbl[sel_idx];

	ep0_fifo_ram u_ram (
		.clk     (CLK),
		.reset_n (RESET_N),
		.we      (mem_we),
		.waddr   (mem_waddr),
		.wdata   (mem_wdata),
		.re      (FIFO_RD | TX_REQ),
		.raddr   (r_reg.rd_ptr[4:0]),
		.rdata   (mem_rdata)
	);

	ep_fifo_layout u_layout (
		.ep        (sel_ok ? ENDPOINT_SELECT : 3'h1),
		.in_max    (r_reg.in_max[sel_idx]),
		.out_max   (r_reg.out_max[sel_idx]),
		.dbl       (lay_dbl),
		.in_addr   (lay_in),
		.out_addr  (lay_out),
		.in2_addr  (lay_in2),
		.out2_addr (lay_out2),
		.fits      (lay_fits)
	);

	always_comb begin
		logic stall_now;
		logic set_irq;
		logic usb_wr;
		stall_now = 1'b0;
		set_irq   = 1'b0;
		r_next    = r_reg;
		r_next.hs_valid = 1'b0;
		r_next.tx_start = 1'b0;
		// one pointer pair serves both directions: the fifo is never used both ways at once
		usb_wr    = RX_VALID && (r_reg.pk == PK_SETUP || r_reg.pk == PK_OUT)
			&& (r_reg.wr_ptr < EP0_MAX_LEN);
		mem_we    = usb_wr || (FIFO_WR && sel0 && r_reg.wr_ptr < EP0_MAX_LEN);
		mem_waddr = r_reg.wr_ptr[4:0];
		mem_wdata = usb_wr ? RX_DATA : FIFO_WDATA;
		if (mem_we) begin
			r_next.wr_ptr = r_reg.wr_ptr + 6'h01;
		end
		if (FIFO_RD || TX_REQ) begin
			r_next.rd_ptr = r_reg.rd_ptr + 6'h01;
		end
		// clears first so a same-cycle hardware set wins
		if (IRQ_FLAGS_READ) begin
			r_next.irq_flag = 1'b0;
		end
		if (sel0 && SENT_STALL_CLEAR) begin
			r_next.sent_stall = 1'b0;
		end
		if (sel0 && PREMATURE_END_CLEAR) begin
			r_next.prem_end = 1'b0;
		end
		if (sel0 && FORCE_STALL_SET) begin
			r_next.send_stall = 1'b1;
		end
		if (sel0 && DATA_END_SET) begin
			r_next.data_end = 1'b1;
		end
		if (sel0 && TX_PACKET_LOAD) begin
			r_next.tx_loaded = 1'b1;
			r_next.tx_len    = r_reg.wr_ptr;
		end
		if (sel0 && RX_PACKET_RELEASE && r_reg.rx_waiting) begin
			r_next.rx_waiting = 1'b0;
			r_next.wr_ptr     = '0;
			r_next.rd_ptr     = '0;
			if (r_reg.st == EP0_IDLE && r_reg.has_data && !r_next.data_end) begin
				r_next.st       = r_reg.dir_in ? EP0_TX : EP0_RX;
				r_next.has_data = 1'b0;
			end
		end
		if (CFG_WR && sel_ok) begin
			r_next.in_max[sel_idx]  = CFG_IN_MAX;
			r_next.out_max[sel_idx] = CFG_OUT_MAX;
			r_next.in_iso[sel_idx]  = CFG_IN_ISO;
			r_next.out_iso[sel_idx] = CFG_OUT_ISO;
			r_next.in_dbl[sel_idx]  = CFG_IN_DBL;
			r_next.out_dbl[sel_idx] = CFG_OUT_DBL;
		end
		// tokens to endpoint 0
		if (TOK_VALID && TOK_EP == 4'h0) begin
			r_next.pk = PK_NONE;
			if (TOK_PID == PID_SETUP) begin
				if (r_reg.st != EP0_IDLE) begin
					r_next.prem_end = 1'b1;
					set_irq         = 1'b1;
				end
				r_next.st       = EP0_IDLE;
				r_next.pk       = PK_SETUP;
				r_next.wr_ptr   = '0;
				r_next.rx_cnt   = '0;
				r_next.has_data = 1'b0;
				r_next.data_end = 1'b0;
				r_next.tx_loaded = 1'b0;
			end else if (r_reg.send_stall && (TOK_PID == PID_IN || TOK_PID == PID_OUT)) begin
				stall_now = 1'b1;
			end else if (TOK_PID == PID_IN) begin
				case (r_reg.st)
					EP0_TX: begin
						if (r_reg.tx_loaded) begin
							r_next.pk       = PK_IN;
							r_next.tx_start = 1'b1;
							r_next.rd_ptr   = '0;
						end else if (r_reg.data_end) begin
							stall_now = 1'b1;
						end else begin
							r_next.hs_valid = 1'b1;
							r_next.hs_code  = HS_NAK;
						end
					end
					EP0_RX: begin
						if (r_reg.data_end && !r_reg.rx_waiting) begin
							r_next.pk       = PK_STATUS;
							r_next.tx_len   = '0;
							r_next.tx_start = 1'b1;
						end else begin
							r_next.prem_end = 1'b1;
							r_next.st       = EP0_IDLE;
							set_irq         = 1'b1;
						end
					end
					EP0_IDLE: begin
						if (r_reg.data_end && !r_reg.rx_waiting) begin
							r_next.pk       = PK_STATUS;
							r_next.tx_len   = '0;
							r_next.tx_start = 1'b1;
						end else begin
							r_next.hs_valid = 1'b1;
							r_next.hs_code  = HS_NAK;
						end
					end
					default: begin
						r_next.st = EP0_IDLE;
					end
				endcase
			end else if (TOK_PID == PID_OUT) begin
				case (r_reg.st)
					EP0_TX: begin
						if (r_reg.data_end && !r_reg.tx_loaded) begin
							r_next.pk     = PK_STATUS;
							r_next.rx_cnt = '0;
						end else begin
							r_next.prem_end = 1'b1;
							r_next.st       = EP0_IDLE;
							set_irq         = 1'b1;
						end
					end
					EP0_RX: begin
						if (r_reg.data_end) begin
							stall_now = 1'b1;
						end else if (r_reg.rx_waiting) begin
							r_next.hs_valid = 1'b1;
							r_next.hs_code  = HS_NAK;
						end else begin
							r_next.pk     = PK_OUT;
							r_next.wr_ptr = '0;
							r_next.rx_cnt = '0;
						end
					end
					default: begin
						r_next.hs_valid = 1'b1;
						r_next.hs_code  = HS_NAK;
					end
				endcase
			end
		end
		// incoming data bytes
		if (RX_VALID && (r_reg.pk == PK_SETUP || r_reg.pk == PK_OUT || r_reg.pk == PK_STATUS)) begin
			if (r_reg.rx_cnt != CNT_SAT) begin
				r_next.rx_cnt = r_reg.rx_cnt + 6'h01;
			end
			if (r_reg.pk == PK_SETUP) begin
				if (r_reg.rx_cnt == REQTYPE_IDX) begin
					r_next.dir_in = RX_DATA[DIR_BIT];
				end
				if ((r_reg.rx_cnt == WLEN_LO_IDX || r_reg.rx_cnt == WLEN_HI_IDX)
					&& RX_DATA != 8'h00) begin
					r_next.has_data = 1'b1;
				end
			end
		end
		// end of a data packet from the host; flags change with the handshake
		if (RX_END && r_reg.pk != PK_NONE && r_reg.pk != PK_IN) begin
			r_next.pk = PK_NONE;
			case (r_reg.pk)
				PK_SETUP: begin
					if (r_reg.rx_cnt == SETUP_LEN) begin
						r_next.hs_valid   = 1'b1;
						r_next.hs_code    = HS_ACK;
						r_next.rx_waiting = 1'b1;
						r_next.cnt_out    = r_reg.rx_cnt;
						set_irq           = 1'b1;
					end else begin
						r_next.wr_ptr = '0;
					end
				end
				PK_OUT: begin
					if (r_reg.rx_cnt > EP0_MAX_LEN) begin
						stall_now = 1'b1;
					end else begin
						r_next.hs_valid   = 1'b1;
						r_next.hs_code    = HS_ACK;
						r_next.rx_waiting = 1'b1;
						r_next.cnt_out    = r_reg.rx_cnt;
						set_irq           = 1'b1;
					end
				end
				PK_STATUS: begin
					if (r_reg.rx_cnt != 6'h00) begin
						stall_now = 1'b1;
					end else begin
						r_next.hs_valid = 1'b1;
						r_next.hs_code  = HS_ACK;
						r_next.st       = EP0_IDLE;
						r_next.data_end = 1'b0;
						set_irq         = 1'b1;
					end
				end
				default: begin
					r_next.pk = PK_NONE;
				end
			endcase
		end
		// host acknowledged our data packet
		if (HOST_ACK && r_reg.pk == PK_IN) begin
			r_next.pk        = PK_NONE;
			r_next.tx_loaded = 1'b0;
			r_next.wr_ptr    = '0;
			set_irq          = 1'b1;
		end
		if (HOST_ACK && r_reg.pk == PK_STATUS) begin
			r_next.pk       = PK_NONE;
			r_next.st       = EP0_IDLE;
			r_next.data_end = 1'b0;
			set_irq         = 1'b1;
		end
		if (stall_now) begin
			r_next.hs_valid   = 1'b1;
			r_next.hs_code    = HS_STALL;
			r_next.sent_stall = 1'b1;
			r_next.send_stall = 1'b0;
			r_next.st         = EP0_IDLE;
			r_next.pk         = PK_NONE;
			r_next.data_end   = 1'b0;
			set_irq           = 1'b1;
		end
		if (set_irq) begin
			r_next.irq_flag = 1'b1;
		end
		r_next.in_addr   = lay_in;
		r_next.out_addr  = lay_out;
		r_next.in2_addr  = lay_in2;
		r_next.out2_addr = lay_out2;
		r_next.fits      = lay_fits;
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign TX_START            = r_reg.tx_start;
	assign TX_LEN              = r_reg.tx_len;
	assign TX_DATA             = mem_rdata;
	assign FIFO_RDATA          = mem_rdata;
	assign HS_VALID            = r_reg.hs_valid;
	assign HS_CODE             = r_reg.hs_code;
	assign IN_MAX_PACKET_SIZE  = r_reg.in_max[sel_idx];
	assign OUT_MAX_PACKET_SIZE = r_reg.out_max[sel_idx];
	assign IN_ISO_SELECT       = r_reg.in_iso[sel_idx];
	assign OUT_ISO_SELECT      = r_reg.out_iso[sel_idx];
	assign IN_BUF_ADDR         = r_reg.in_addr;
	assign OUT_BUF_ADDR        = r_reg.out_addr;
	assign IN_BUF2_ADDR        = r_reg.in2_addr;
	assign OUT_BUF2_ADDR       = r_reg.out2_addr;
	assign CFG_FITS            = r_reg.fits;
	assign EP0_STATE           = r_reg.st;
	assign RX_PACKET_WAITING   = r_reg.rx_waiting;
	assign TX_PACKET_LOADED    = r_reg.tx_loaded;
	assign DATA_END            = r_reg.data_end;
	assign FORCE_STALL         = r_reg.send_stall;
	assign SENT_STALL          = r_reg.sent_stall;
	assign PREMATURE_END       = r_reg.prem_end;
	// count is meaningful only while a packet waits
	assign EP0_RX_BYTE_COUNT   = r_reg.rx_waiting ? r_reg.cnt_out : 6'h00;
	assign EP0_IRQ_FLAG        = r_reg.irq_flag;
	assign USB_IRQ             = r_reg.irq_flag & EP0_IRQ_MASK & GLOBAL_USB_IRQ_ENABLE;
endmodule

// ==== common/usb_ep_pkg.sv ====
// shared constants and types for the endpoint logic
package usb_ep_pkg;
	localparam int          EP0_AW        = 5;
	localparam int          EP0_DEPTH     = 32;
	localparam logic [5:0]  EP0_MAX_LEN   = 6'h20;
	localparam logic [5:0]  CNT_SAT       = 6'h3f;
	localparam logic [5:0]  SETUP_LEN     = 6'h08;
	localparam logic [5:0]  REQTYPE_IDX   = 6'h00;
	localparam logic [5:0]  WLEN_LO_IDX   = 6'h06;
	localparam logic [5:0]  WLEN_HI_IDX   = 6'h07;
	localparam int          DIR_BIT       = 7;
	localparam int          NUM_EP        = 5;
	localparam int          MAXP_W        = 10;
	localparam int          ADDR_W        = 10;
	localparam logic [10:0] EP1_FIFO_SIZE = 11'h020;
	localparam logic [1:0]  PID_SETUP     = 2'h0;
	localparam logic [1:0]  PID_IN        = 2'h1;
	localparam logic [1:0]  PID_OUT       = 2'h2;
	localparam logic [1:0]  HS_ACK        = 2'h0;
	localparam logic [1:0]  HS_NAK        = 2'h1;
	localparam logic [1:0]  HS_STALL      = 2'h2;
	localparam logic [2:0]  EP0_SEL       = 3'h0;

	typedef enum logic [1:0] {EP0_IDLE, EP0_TX, EP0_RX} ep0_state_t;
	typedef enum logic [2:0] {PK_NONE, PK_SETUP, PK_OUT, PK_STATUS, PK_IN} pkt_t;
endpackage

// ==== hw/ep0_fifo_ram.sv ====
// endpoint 0 packet memory, one write port and one registered read port
`timescale 1ns/1ps
module ep0_fifo_ram
	import usb_ep_pkg::*;
#(
	parameter int DEPTH = EP0_DEPTH,
	parameter int AW    = EP0_AW
) (
	input  wire logic          clk,
	input  wire logic          reset_n,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	input  wire logic          re,
	input  wire logic [AW-1:0] raddr,
	output logic      [7:0]    rdata
);
	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [7:0]            rdata;
	} ram_t;

	ram_t r_reg;
	ram_t r_next;

	always_comb begin
		r_next = r_reg;
		if (we) begin
			r_next.mem[waddr] = wdata;
		end
		if (re) begin
			r_next.rdata = r_reg.mem[raddr];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign rdata = r_reg.rdata;
endmodule

// ==== hw/ep_fifo_layout.sv ====
// buffer start addresses and fit check for one endpoint region
`timescale 1ns/1ps
module ep_fifo_layout
	import usb_ep_pkg::*;
(
	input  wire logic [2:0]        ep,
	input  wire logic [MAXP_W-1:0] in_max,
	input  wire logic [MAXP_W-1:0] out_max,
	input  wire logic              dbl,
	output logic      [ADDR_W-1:0] in_addr,
	output logic      [ADDR_W-1:0] out_addr,
	output logic      [ADDR_W-1:0] in2_addr,
	output logic      [ADDR_W-1:0] out2_addr,
	output logic                   fits
);
	logic [10:0] size;
	logic [10:0] half;
	logic [10:0] sum;
	logic [10:0] top;

	// regions double in size, so each region's base equals its size
	always_comb begin
		size      = EP1_FIFO_SIZE << (ep - 3'h1);
		half      = size >> 1;
		sum       = {1'b0, in_max} + {1'b0, out_max};
		top       = size + size - 11'h001;
		in_addr   = top[ADDR_W-1:0];
		out_addr  = size[ADDR_W-1:0];
		out2_addr = 10'(size + half);
		in2_addr  = 10'(size + half - 11'h001);
		fits      = dbl ? (sum <= half) : (sum <= size);
	end
endmodule

// ==== tb/usb_cef_chk.sv ====
// port-level assertions for the endpoint 0 engine
`timescale 1ns/1ps
module usb_cef_chk
	import usb_ep_pkg::*;
(
	input wire logic       CLK,
	input wire logic       RESET_N,
	input wire logic       TOK_VALID,
	input wire logic [1:0] TOK_PID,
	input wire logic [3:0] TOK_EP,
	input wire logic       HOST_ACK,
	input wire logic       HS_VALID,
	input wire logic [1:0] HS_CODE,
	input wire logic [1:0] EP0_STATE,
	input wire logic       TX_PACKET_LOADED,
	input wire logic       DATA_END,
	input wire logic       FORCE_STALL,
	input wire logic       SENT_STALL,
	input wire logic       PREMATURE_END,
	input wire logic       RX_PACKET_WAITING,
	input wire logic [5:0] EP0_RX_BYTE_COUNT,
	input wire logic       EP0_IRQ_FLAG,
	input wire logic       EP0_IRQ_MASK,
	input wire logic       GLOBAL_USB_IRQ_ENABLE,
	input wire logic       USB_IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	wire stall = HS_VALID && HS_CODE == HS_STALL;
	wire tok_in = TOK_VALID && TOK_PID == PID_IN && TOK_EP == 4'h0;
	// an empty TX endpoint naks until the last packet has gone; after that an IN is an error
	wire tx_empty = EP0_STATE == EP0_TX && !TX_PACKET_LOADED && !FORCE_STALL;
	a_stall_flag_irq: assert property (stall |-> ##[0:1] (SENT_STALL && EP0_IRQ_FLAG))
		else $error("stall sent without flag");
	a_stall_to_idle: assert property (stall |-> ##[0:1] EP0_STATE == EP0_IDLE)
		else $error("stall left ep0 busy");
	a_nak_unloaded: assert property (tok_in && tx_empty && !DATA_END
		|=> HS_VALID && HS_CODE == HS_NAK)
		else $error("no nak for empty ep0");
	a_in_after_end: assert property (tok_in && tx_empty && DATA_END |=> stall)
		else $error("extra in token not stalled");
	a_force_stall: assert property (tok_in && FORCE_STALL |=> stall)
		else $error("forced stall not sent");
	a_sent_clears: assert property (HOST_ACK && EP0_STATE == EP0_TX && TX_PACKET_LOADED
		|=> !TX_PACKET_LOADED && EP0_IRQ_FLAG)
		else $error("loaded bit kept after ack");
	a_early_end: assert property ($rose(PREMATURE_END) |-> EP0_STATE == EP0_IDLE && EP0_IRQ_FLAG)
		else $error("premature end not idle");
	a_count_valid: assert property (!RX_PACKET_WAITING |-> EP0_RX_BYTE_COUNT == 6'h00)
		else $error("count shown without packet");
	a_count_bound: assert property ($rose(RX_PACKET_WAITING)
		|-> EP0_RX_BYTE_COUNT <= EP0_MAX_LEN && EP0_IRQ_FLAG)
		else $error("packet flagged with bad count");
	a_irq_gate: assert property (USB_IRQ == (EP0_IRQ_FLAG && EP0_IRQ_MASK && GLOBAL_USB_IRQ_ENABLE))
		else $error("irq request gating wrong");
	a_state_legal: assert property (EP0_STATE != 2'h3)
		else $error("illegal ep0 state");
	c_stall: cover property (stall);
	c_nak: cover property (HS_VALID && HS_CODE == HS_NAK);
	c_early: cover property ($rose(PREMATURE_END));
endmodule
bind usb_control_endpoint_fifo usb_cef_chk chk (.*);

// ==== tb/usb_host_model.sv ====
// host model: tokens and data packets out, drains IN packets and acks them
`timescale 1ns/1ps
module usb_host_model
	import usb_ep_pkg::*;
(
	input  wire logic       CLK,
	input  wire logic       TX_START,
	input  wire logic [5:0] TX_LEN,
	input  wire logic [7:0] TX_DATA,
	output logic            TOK_VALID,
	output logic [1:0]      TOK_PID,
	output logic [3:0]      TOK_EP,
	output logic            RX_VALID,
	output logic [7:0]      RX_DATA,
	output logic            RX_END,
	output logic            HOST_ACK,
	output logic            TX_REQ
);
	initial {TOK_VALID, TOK_PID, TOK_EP, RX_VALID, RX_DATA, RX_END, HOST_ACK, TX_REQ} = '0;
	// running sum of the bytes drained from IN packets, judged by the bench
	logic [7:0] in_sum = 8'h00;
	task tok(input logic [1:0] p);
		@(posedge CLK);
		TOK_VALID <= 1'b1;
		TOK_PID <= p;
		@(posedge CLK);
		TOK_VALID <= 1'b0;
		TOK_PID <= 2'h3;
	endtask
	// bytes 6 and 7 carry the length field of a setup packet
	task pkt(input int n, input logic [7:0] b0, input logic [7:0] wl);
		for (int i = 0; i < n; i++) begin
			@(posedge CLK);
			RX_VALID <= 1'b1;
			RX_DATA <= (i == 0) ? b0 : (i == 6) ? wl : 8'h00;
		end
		@(posedge CLK);
		RX_VALID <= 1'b0;
		RX_DATA <= ~RX_DATA;
		RX_END <= 1'b1;
		@(posedge CLK);
		RX_END <= 1'b0;
	endtask
	always @(posedge CLK) begin
		if (TX_START) begin
			repeat (TX_LEN) begin
				TX_REQ <= 1'b1;
				@(posedge CLK);
				TX_REQ <= 1'b0;
				@(posedge CLK);
				in_sum <= in_sum + TX_DATA;
			end
			HOST_ACK <= 1'b1;
			@(posedge CLK);
			HOST_ACK <= 1'b0;
		end
	end
endmodule

// ==== tb/usb_control_endpoint_fifo_tb_top.sv ====
// self-checking bench for the endpoint 0 engine and fifo layout
`timescale 1ns/1ps
`define CK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
	$display("ERROR %0t got %h exp %h", $time, a, e); end end
module usb_control_endpoint_fifo_tb_top
	import usb_ep_pkg::*;
;
	logic CLK = 0, RESET_N = 0, FIFO_WR = 0, FIFO_RD = 0, CFG_WR = 0;
	logic EP0_IRQ_MASK = 1, GLOBAL_USB_IRQ_ENABLE = 1, CFG_IN_ISO = 0, CFG_OUT_ISO = 0;
	logic CFG_IN_DBL = 0, CFG_OUT_DBL = 0;
	logic TOK_VALID, RX_VALID, RX_END, HOST_ACK, TX_REQ, TX_START, HS_VALID;
	logic IN_ISO_SELECT, OUT_ISO_SELECT, CFG_FITS, RX_PACKET_WAITING, TX_PACKET_LOADED;
	logic DATA_END, FORCE_STALL, SENT_STALL, PREMATURE_END, EP0_IRQ_FLAG, USB_IRQ;
	logic [1:0] TOK_PID, HS_CODE, EP0_STATE, hsc;
	logic [3:0] TOK_EP;
	logic [7:0] RX_DATA, TX_DATA, FIFO_RDATA, FIFO_WDATA = 0;
	logic [5:0] TX_LEN, EP0_RX_BYTE_COUNT;
	logic [6:0] fs = 0;
	logic [2:0] ENDPOINT_SELECT = 0;
	logic [MAXP_W-1:0] CFG_IN_MAX = 0, CFG_OUT_MAX = 0, IN_MAX_PACKET_SIZE, OUT_MAX_PACKET_SIZE;
	logic [ADDR_W-1:0] IN_BUF_ADDR, OUT_BUF_ADDR, IN_BUF2_ADDR, OUT_BUF2_ADDR;
	wire logic TX_PACKET_LOAD, DATA_END_SET, RX_PACKET_RELEASE, FORCE_STALL_SET;
	wire logic SENT_STALL_CLEAR, PREMATURE_END_CLEAR, IRQ_FLAGS_READ;
	int miscompares = 0, cmp_count = 0, k;
	assign {IRQ_FLAGS_READ, PREMATURE_END_CLEAR, SENT_STALL_CLEAR, FORCE_STALL_SET,
		RX_PACKET_RELEASE, DATA_END_SET, TX_PACKET_LOAD} = fs;
	always #5 CLK = ~CLK;
	usb_control_endpoint_fifo uut (.*);
	usb_host_model host (.*);
	task test_done;
		$display("counts: %0d miscompares of %0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task fw(input logic [6:0] m);
		@(posedge CLK) fs <= m;
		@(posedge CLK) fs <= 7'h00;
		#1;
	endtask
	// code 3 stands for no handshake seen
	task hs(input logic [1:0] e);
		hsc = 2'h3;
		#1;
		repeat (6) begin
			if (HS_VALID === 1'b1) hsc = HS_CODE;
			@(posedge CLK);
			#1;
		end
		`CK(hsc, e)
	endtask
	task setup(input logic [7:0] b0, input logic [7:0] wl);
		host.tok(PID_SETUP);
		host.pkt(8, b0, wl);
		hs(HS_ACK);
	endtask
	task s_setup;
		host.tok(PID_SETUP);
		host.pkt(7, 8'h80, 8'h04);
		hs(2'h3);
		setup(8'h80, 8'h04);
		`CK(EP0_RX_BYTE_COUNT, SETUP_LEN)
		@(posedge CLK) FIFO_RD <= 1'b1;
		@(posedge CLK) FIFO_RD <= 1'b0;
		#1 `CK(FIFO_RDATA, 8'h80)
		fw(7'h40);
		`CK(EP0_IRQ_FLAG, 1'b0)
		fw(7'h04);
		`CK(EP0_STATE, EP0_TX)
	endtask
	task s_tx;
		host.tok(PID_IN);
		hs(HS_NAK);
		for (int i = 0; i < 4; i++) @(posedge CLK) {FIFO_WR, FIFO_WDATA} <= {1'b1, 8'(i)};
		@(posedge CLK) FIFO_WR <= 1'b0;
		fw(7'h03);
		host.tok(PID_IN);
		for (k = 0; k < 40 && TX_PACKET_LOADED !== 1'b0; k++) @(posedge CLK);
		if (k == 40) begin miscompares++; test_done; end
		`CK(TX_LEN, 6'h04)
		`CK(host.in_sum, 8'h06)
		host.tok(PID_IN);
		hs(HS_STALL);
		`CK(SENT_STALL, 1'b1)
		fw(7'h10);
		`CK(SENT_STALL, 1'b0)
	endtask
	task s_out;
		setup(8'h00, 8'h04);
		fw(7'h04);
		host.tok(PID_OUT);
		host.pkt(4, 8'h5a, 8'h00);
		hs(HS_ACK);
		`CK({RX_PACKET_WAITING, EP0_RX_BYTE_COUNT}, {1'b1, 6'h04})
		@(posedge CLK) FIFO_RD <= 1'b1;
		@(posedge CLK) FIFO_RD <= 1'b0;
		#1 `CK(FIFO_RDATA, 8'h5a)
		fw(7'h06);
		host.tok(PID_IN);
		hs(2'h3);
		`CK({EP0_STATE, DATA_END, TX_LEN}, {EP0_IDLE, 1'b0, 6'h00})
	endtask
	// a zero-length last IN packet, then a good and a bad status packet
	task s_status;
		for (int n = 0; n < 2; n++) begin
			setup(8'h80, 8'h01);
			fw(7'h04);
			fw(7'h43);
			host.tok(PID_IN);
			hs(2'h3);
			`CK({TX_PACKET_LOADED, EP0_IRQ_FLAG}, 2'b01)
			host.tok(PID_OUT);
			host.pkt(n, 8'h00, 8'h00);
			hs(n ? HS_STALL : HS_ACK);
			`CK({EP0_STATE, DATA_END, SENT_STALL}, {EP0_IDLE, 1'b0, 1'(n)})
		end
		fw(7'h10);
	endtask
	task s_rx;
		setup(8'h00, 8'h04);
		fw(7'h04);
		`CK(EP0_STATE, EP0_RX)
		host.tok(PID_IN);
		hs(2'h3);
		`CK(PREMATURE_END, 1'b1)
		fw(7'h20);
		`CK(PREMATURE_END, 1'b0)
		setup(8'h00, 8'h40);
		fw(7'h04);
		host.tok(PID_OUT);
		host.pkt(33, 8'h00, 8'h00);
		hs(HS_STALL);
		fw(7'h18);
		host.tok(PID_IN);
		hs(HS_STALL);
		`CK(FORCE_STALL, 1'b0)
	endtask
	task cfg(input logic [9:0] i, input logic d);
		@(posedge CLK) {CFG_WR, CFG_IN_MAX, CFG_OUT_MAX, CFG_IN_DBL, CFG_IN_ISO, CFG_OUT_ISO}
			<= {1'b1, i, 10'h010, d, 1'b1, d};
		@(posedge CLK) CFG_WR <= 1'b0;
		repeat (2) @(posedge CLK);
		#1;
	endtask
	task s_cfg;
		@(posedge CLK) ENDPOINT_SELECT <= 3'h2;
		cfg(10'h010, 1'b0);
		`CK({IN_ISO_SELECT, OUT_ISO_SELECT}, 2'b10)
		`CK(IN_BUF_ADDR, 10'h07f)
		`CK({OUT_BUF_ADDR, CFG_FITS}, {10'h040, 1'b1})
		cfg(10'h010, 1'b1);
		`CK({IN_BUF2_ADDR, OUT_BUF2_ADDR}, {10'h05f, 10'h060})
		`CK(OUT_ISO_SELECT, 1'b1)
		cfg(10'h018, 1'b1);
		`CK(CFG_FITS, 1'b0)
		`CK({IN_MAX_PACKET_SIZE, OUT_MAX_PACKET_SIZE}, {10'h018, 10'h010})
		@(posedge CLK) ENDPOINT_SELECT <= 3'h3;
		#1 `CK({IN_MAX_PACKET_SIZE, IN_ISO_SELECT}, 11'h000)
	endtask
	// the flag stays set from the last stall; only mask and enable together raise the request
	task s_irq;
		for (int m = 0; m < 4; m++) begin
			@(posedge CLK) {EP0_IRQ_MASK, GLOBAL_USB_IRQ_ENABLE} <= 2'(m);
			#1 `CK({EP0_IRQ_FLAG, USB_IRQ}, {1'b1, m == 3})
		end
		fw(7'h40);
		`CK({EP0_IRQ_FLAG, USB_IRQ}, 2'b00)
	endtask
	initial begin
		repeat (3) @(posedge CLK);
		RESET_N <= 1'b1;
		@(posedge CLK);
		#1 `CK(EP0_STATE, EP0_IDLE)
		s_setup;
		s_tx;
		s_out;
		s_status;
		s_rx;
		s_cfg;
		s_irq;
		test_done;
	end
endmodule
